// ==== pkg/bcu_consts.vh ====
// constants of the breakpoint comparator unit
// ----------------------------------------
// ----------------------------------------
`ifndef BCU_CONSTS_VH
`define BCU_CONSTS_VH
// register offsets
`define BCU_CTL_ONE 4'h0
`define BCU_CTL_TWO 4'h1
`define BCU_CTL_THREE 4'h2
`define BCU_STATUS 4'h3
`define BCU_A_EXT 4'h4
`define BCU_A_HIGH 4'h5
`define BCU_A_LOW 4'h6
`define BCU_B_EXT 4'h7
`define BCU_B_HIGH 4'h8
`define BCU_B_LOW 4'h9
`define BCU_C_EXT 4'hA
`define BCU_C_HIGH 4'hB
`define BCU_C_LOW 4'hC
// control one fields
`define BCU_TRACE_EN 7
`define BCU_TRG_SEL 6
`define BCU_FULL_TRACE 5
// control two fields
`define BCU_BKP_EN 7
`define BCU_FULL_BKP 6
`define BCU_BDM_SEL 5
`define BCU_AB_TAG 4
`define BCU_C_EN 3
`define BCU_C_TAG 2
`define BCU_C_RWEN 1
`define BCU_C_RSEL 0
// control three fields
`define BCU_A_MH 7
`define BCU_A_ML 6
`define BCU_B_MH 5
`define BCU_B_ML 4
`define BCU_A_RWEN 3
`define BCU_A_RSEL 2
`define BCU_B_RWEN 1
`define BCU_B_RSEL 0
// reset value of every register
`define BCU_REG_RESET 8'h00
`endif

// ==== rtl/bcu_breakpoint_comparator.v ====
// breakpoint and comparator logic of the on-chip debug unit
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "bcu_consts.vh"

module bcu_breakpoint_comparator #(
	parameter ADDR_W = 4
) (
	input wire clock,
	input wire sys_rst,
	input wire [ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	input wire bus_valid,
	input wire [15:0] bus_addr,
	input wire [21:14] bus_xaddr,
	input wire bus_flash,
	input wire bus_rw,
	input wire [15:0] bus_data,
	input wire instr_boundary,
	input wire exec_strobe,
	input wire [15:0] exec_addr,
	input wire [21:14] exec_xaddr,
	input wire exec_flash,
	input wire background_active,
	input wire single_step_command,
	input wire external_break,
	input wire secured,
	output reg background_request,
	output reg software_interrupt_request,
	output reg match_a,
	output reg match_b,
	output reg match_c,
	output reg trace_mode
);

// ----------------------------------------
// comparison functions
// ----------------------------------------

// address compare with byte masks and extended page bits
function addr_hit;
	input [7:0] ext;
	input [7:0] hi;
	input [7:0] lo;
	input [15:0] a;
	input [21:14] x;
	input flash;
	input trc;
	input mh;
	input ml;
	reg use_x;
	reg ext_ok;
	reg hi_ok;
	begin
		use_x = trc ? ext[6] : flash;
		if (trc)
			ext_ok = !use_x || (ext[5:0] == x[21:16]);
		else
			ext_ok = !use_x || (ext[5:0] == x[19:14]);
		if (trc && use_x)
			hi_ok = (hi == {x[15:14], a[13:8]});
		else if (!trc && flash)
			hi_ok = (hi[5:0] == a[13:8]);
		else
			hi_ok = (hi == a[15:8]);
		addr_hit = ext_ok && (hi_ok || (mh && ml)) && (lo == a[7:0] || ml);
	end
endfunction

// data compare on selected bytes
function data_hit;
	input [7:0] hi;
	input [7:0] lo;
	input [15:0] d;
	input mh;
	input ml;
	begin
		data_hit = (mh || hi == d[15:8]) && (ml || lo == d[7:0]);
	end
endfunction

// read/write qualifier
function rw_ok;
	input en;
	input sel;
	input rw;
	begin
		rw_ok = !en || (sel == rw);
	end
endfunction

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] debug_control_one;
reg [7:0] debug_control_two;
reg [7:0] debug_control_three;
reg [7:0] cmp_a_extended;
reg [7:0] cmp_a_high;
reg [7:0] cmp_a_low;
reg [7:0] cmp_b_extended;
reg [7:0] cmp_b_high;
reg [7:0] cmp_b_low;
reg [7:0] cmp_c_extended;
reg [7:0] cmp_c_high;
reg [7:0] cmp_c_low;
reg force_pend_ab;
reg force_pend_c;
reg [7:0] next_rdata;

// field aliases
wire trace_mode_enable = debug_control_one[`BCU_TRACE_EN];
wire tagged_trigger_select = debug_control_one[`BCU_TRG_SEL];
wire full_trace = debug_control_one[`BCU_FULL_TRACE];
wire breakpoint_mode_enable = debug_control_two[`BCU_BKP_EN];
wire full_bkp = debug_control_two[`BCU_FULL_BKP];
wire background_select = debug_control_two[`BCU_BDM_SEL];
wire ab_tag_select = debug_control_two[`BCU_AB_TAG];
wire cmp_c_break_enable = debug_control_two[`BCU_C_EN];
wire cmp_c_tag_select = debug_control_two[`BCU_C_TAG];
wire cmp_c_rdwr_enable = debug_control_two[`BCU_C_RWEN];
wire cmp_c_read_select = debug_control_two[`BCU_C_RSEL];
wire a_mh = debug_control_three[`BCU_A_MH];
wire a_ml = debug_control_three[`BCU_A_ML];
wire b_mh = debug_control_three[`BCU_B_MH];
wire b_ml = debug_control_three[`BCU_B_ML];
wire cmp_a_rdwr_enable = debug_control_three[`BCU_A_RWEN];
wire cmp_a_read_select = debug_control_three[`BCU_A_RSEL];
wire cmp_b_rdwr_enable = debug_control_three[`BCU_B_RWEN];
wire cmp_b_read_select = debug_control_three[`BCU_B_RSEL];

// ----------------------------------------
// mode selection
// ----------------------------------------
wire bkp = breakpoint_mode_enable;
wire trc = !bkp && trace_mode_enable && !secured;
wire full = bkp ? full_bkp : full_trace;

// ----------------------------------------
// raw comparator results on bus cycles and executed opcodes
// ----------------------------------------
wire a_bus = addr_hit(cmp_a_extended, cmp_a_high, cmp_a_low, bus_addr,
	bus_xaddr, bus_flash, trc, a_mh, a_ml);
wire b_bus_addr = addr_hit(cmp_b_extended, cmp_b_high, cmp_b_low, bus_addr,
	bus_xaddr, bus_flash, trc, b_mh, b_ml);
wire b_bus_data = data_hit(cmp_b_high, cmp_b_low, bus_data, b_mh, b_ml);
wire c_bus = addr_hit(cmp_c_extended, cmp_c_high, cmp_c_low, bus_addr,
	bus_xaddr, bus_flash, trc, 1'b0, 1'b0);
wire a_exe = addr_hit(cmp_a_extended, cmp_a_high, cmp_a_low, exec_addr,
	exec_xaddr, exec_flash, trc, a_mh, a_ml);
wire b_exe = addr_hit(cmp_b_extended, cmp_b_high, cmp_b_low, exec_addr,
	exec_xaddr, exec_flash, trc, b_mh, b_ml);
wire c_exe = addr_hit(cmp_c_extended, cmp_c_high, cmp_c_low, exec_addr,
	exec_xaddr, exec_flash, trc, 1'b0, 1'b0);

// read/write qualification of A, B and C
wire a_rw = rw_ok(cmp_a_rdwr_enable, cmp_a_read_select, bus_rw);
wire b_rw = full ? a_rw : rw_ok(cmp_b_rdwr_enable, cmp_b_read_select, bus_rw);
wire c_rw = rw_ok(cmp_c_rdwr_enable, cmp_c_read_select, bus_rw);

// ----------------------------------------
// breakpoint mode hits
// ----------------------------------------
// forced hits on bus cycles, full mode needs address and data
wire bk_force_dual = bus_valid && ((a_bus && a_rw) || (b_bus_addr && b_rw));
wire bk_force_full = bus_valid && a_bus && a_rw && b_bus_data;
wire bk_force_ab = bkp && !ab_tag_select &&
	(full ? bk_force_full : bk_force_dual);
wire bk_force_c = bkp && cmp_c_break_enable && !cmp_c_tag_select &&
	bus_valid && c_bus && c_rw;
// tagged hits just before execution, full mode compares address only
wire bk_tag_ab = bkp && ab_tag_select && exec_strobe &&
	(full ? a_exe : (a_exe || b_exe));
wire bk_tag_c = bkp && cmp_c_break_enable && cmp_c_tag_select &&
	exec_strobe && c_exe;

// ----------------------------------------
// trace mode matches
// ----------------------------------------
// tagged C breakpoint in trace mode shadows tagged A/B at same opcode
wire trc_tag_c = trc && cmp_c_break_enable && cmp_c_tag_select &&
	exec_strobe && c_exe;
wire trc_force_c = trc && cmp_c_break_enable && !cmp_c_tag_select &&
	bus_valid && c_bus && c_rw;
// full mode data compare is gated by the A read/write bits
wire trc_b_full = bus_valid && b_bus_data && a_rw;
wire trc_a = tagged_trigger_select ?
	(exec_strobe && a_exe && !trc_tag_c) :
	(bus_valid && a_bus && a_rw);
wire trc_b = tagged_trigger_select ?
	(!full && exec_strobe && b_exe && !trc_tag_c) :
	(full ? trc_b_full : (bus_valid && b_bus_addr && b_rw));

// ----------------------------------------
// breakpoint arbitration
// ----------------------------------------
// debug firmware blocks all; single step blocks tagging into debug
wire allow = !background_active && !external_break;
wire tag_ok = !(single_step_command && background_select);
wire tag_hit = bk_tag_ab || bk_tag_c || trc_tag_c;
wire force_fire = instr_boundary && (force_pend_ab || force_pend_c);
wire fire = allow && ((tag_hit && tag_ok) || force_fire);

// pending forced hits, held until the next instruction boundary
always @(posedge clock) begin
	if (sys_rst) begin
		force_pend_ab <= 1'b0;
		force_pend_c <= 1'b0;
	end else if (background_active || !(bkp || trc)) begin
		force_pend_ab <= 1'b0;
		force_pend_c <= 1'b0;
	end else begin
		// a new hit in the boundary cycle stays pending
		force_pend_ab <= bk_force_ab || (force_pend_ab && !force_fire);
		force_pend_c <= bk_force_c || trc_force_c ||
			(force_pend_c && !force_fire);
	end
end

// request pulses and match outputs, one cycle each
always @(posedge clock) begin
	if (sys_rst) begin
		background_request <= 1'b0;
		software_interrupt_request <= 1'b0;
		match_a <= 1'b0;
		match_b <= 1'b0;
		match_c <= 1'b0;
		trace_mode <= 1'b0;
	end else begin
		// one request only, chosen by the background select bit
		background_request <= fire && background_select;
		software_interrupt_request <= fire && !background_select;
		match_a <= trc && trc_a;
		match_b <= trc && trc_b;
		match_c <= trc_tag_c || trc_force_c;
		trace_mode <= trc;
	end
end

// ----------------------------------------
// register bus
// ----------------------------------------
// register writes
always @(posedge clock) begin
	if (sys_rst) begin
		debug_control_one <= `BCU_REG_RESET;
		debug_control_two <= `BCU_REG_RESET;
		debug_control_three <= `BCU_REG_RESET;
		cmp_a_extended <= `BCU_REG_RESET;
		cmp_a_high <= `BCU_REG_RESET;
		cmp_a_low <= `BCU_REG_RESET;
		cmp_b_extended <= `BCU_REG_RESET;
		cmp_b_high <= `BCU_REG_RESET;
		cmp_b_low <= `BCU_REG_RESET;
		cmp_c_extended <= `BCU_REG_RESET;
		cmp_c_high <= `BCU_REG_RESET;
		cmp_c_low <= `BCU_REG_RESET;
	end else if (reg_write) begin
		case (reg_addr)
			`BCU_CTL_ONE: debug_control_one <= reg_wdata;
			`BCU_CTL_TWO: debug_control_two <= reg_wdata;
			`BCU_CTL_THREE: debug_control_three <= reg_wdata;
			`BCU_A_EXT: cmp_a_extended <= reg_wdata;
			`BCU_A_HIGH: cmp_a_high <= reg_wdata;
			`BCU_A_LOW: cmp_a_low <= reg_wdata;
			`BCU_B_EXT: cmp_b_extended <= reg_wdata;
			`BCU_B_HIGH: cmp_b_high <= reg_wdata;
			`BCU_B_LOW: cmp_b_low <= reg_wdata;
			`BCU_C_EXT: cmp_c_extended <= reg_wdata;
			`BCU_C_HIGH: cmp_c_high <= reg_wdata;
			`BCU_C_LOW: cmp_c_low <= reg_wdata;
			default: ;
		endcase
	end
end

// read multiplexer, unmapped reads give zero
always @* begin
	case (reg_addr)
		`BCU_CTL_ONE: next_rdata = debug_control_one;
		`BCU_CTL_TWO: next_rdata = debug_control_two;
		`BCU_CTL_THREE: next_rdata = debug_control_three;
		`BCU_STATUS: next_rdata = {3'h0, force_pend_c, force_pend_ab,
			trc, bkp, full};
		`BCU_A_EXT: next_rdata = cmp_a_extended;
		`BCU_A_HIGH: next_rdata = cmp_a_high;
		`BCU_A_LOW: next_rdata = cmp_a_low;
		`BCU_B_EXT: next_rdata = cmp_b_extended;
		`BCU_B_HIGH: next_rdata = cmp_b_high;
		`BCU_B_LOW: next_rdata = cmp_b_low;
		`BCU_C_EXT: next_rdata = cmp_c_extended;
		`BCU_C_HIGH: next_rdata = cmp_c_high;
		`BCU_C_LOW: next_rdata = cmp_c_low;
		default: next_rdata = 8'h00;
	endcase
end

// read data stands one cycle after the strobe, zero otherwise
always @(posedge clock) begin
	if (sys_rst)
		reg_rdata <= 8'h00;
	else if (reg_read)
		reg_rdata <= next_rdata;
	else
		reg_rdata <= 8'h00;
end

endmodule // bcu_breakpoint_comparator
`default_nettype wire

// ==== tb/bcu_breakpoint_comparator_bench.sv ====
// self-checking bench of the breakpoint comparator unit
`timescale 1ns/100ps
`default_nettype none
module bcu_breakpoint_comparator_bench;
	logic clock, sys_rst, reg_write, reg_read, bus_valid, bus_rw, instr_boundary, exec_strobe;
	logic background_active, single_step_command, external_break, secured;
	logic background_request, software_interrupt_request, match_a, match_b, match_c, trace_mode;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [15:0] bus_addr, bus_data, exec_addr;
	logic [21:14] bus_xaddr, exec_xaddr;
	logic bus_flash, exec_flash;
	int bad_count, total_checks, cycles;
	bcu_breakpoint_comparator bcu_breakpoint_comparator_inst (.clock(clock), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .bus_valid(bus_valid), .bus_addr(bus_addr),
		.bus_xaddr(bus_xaddr), .bus_flash(bus_flash), .bus_rw(bus_rw), .bus_data(bus_data),
		.instr_boundary(instr_boundary), .exec_strobe(exec_strobe), .exec_addr(exec_addr),
		.exec_xaddr(exec_xaddr), .exec_flash(exec_flash),
		.background_active(background_active), .single_step_command(single_step_command),
		.external_break(external_break), .secured(secured), .match_a(match_a), .match_b(match_b),
		.background_request(background_request), .match_c(match_c), .trace_mode(trace_mode),
		.software_interrupt_request(software_interrupt_request));
	bcu_core_model bcu_core_model_inst (.clock(clock), .bus_valid(bus_valid), .bus_addr(bus_addr),
		.bus_rw(bus_rw), .bus_data(bus_data), .instr_boundary(instr_boundary),
		.exec_strobe(exec_strobe), .exec_addr(exec_addr));
	// clock and hang guard
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			conclude();
		end
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
		// idle edge so a following write never re-raises the strobe in this step
		@(posedge clock);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 chk({8'h00, reg_rdata}, {8'h00, e});
		@(posedge clock);
	endtask
	// requests {debug entry, software interrupt} just after the firing edge
	task automatic req(input logic [1:0] e);
		#1 chk({14'h0000, background_request, software_interrupt_request}, {14'h0000, e});
		@(posedge clock);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_tag_zero();
		rd(4'h1, 8'h00);
		wr(4'h1, 8'h8F);
		wr(4'hF, 8'hFF);
		wr(4'h3, 8'hFF);
		rd(4'hF, 8'h00);
		rd(4'h3, 8'h02);
		bcu_core_model_inst.tag(16'h1234);
		req(2'b00);
		bcu_core_model_inst.tag(16'h0000);
		req(2'b01);
		wr(4'h1, 8'hAF);
		single_step_command <= 1'b1;
		bcu_core_model_inst.tag(16'h0000);
		req(2'b00);
		single_step_command <= 1'b0;
		bcu_core_model_inst.tag(16'h0000);
		req(2'b10);
	endtask
	task automatic s_forced_c();
		wr(4'h1, 8'h88);
		wr(4'hB, 8'h12);
		wr(4'hC, 8'h34);
		bcu_core_model_inst.cycle(16'h1234, 1'b1, 16'h0000);
		bcu_core_model_inst.boundary();
		req(2'b01);
		wr(4'h1, 8'hA8);
		bcu_core_model_inst.cycle(16'h1234, 1'b0, 16'h0000);
		bcu_core_model_inst.boundary();
		req(2'b10);
		background_active <= 1'b1;
		bcu_core_model_inst.cycle(16'h1234, 1'b1, 16'h0000);
		bcu_core_model_inst.boundary();
		req(2'b00);
		background_active <= 1'b0;
		bcu_core_model_inst.cycle(16'h1234, 1'b1, 16'h0000);
		external_break <= 1'b1;
		bcu_core_model_inst.boundary();
		req(2'b00);
		external_break <= 1'b0;
		// the hit lost beside the external break needs a fresh bus cycle
		bcu_core_model_inst.cycle(16'h1234, 1'b1, 16'h0000);
		bcu_core_model_inst.boundary();
		req(2'b10);
	endtask
	task automatic s_dual_a();
		wr(4'h1, 8'h80);
		wr(4'h2, 8'h0C);
		wr(4'h5, 8'h20);
		bcu_core_model_inst.cycle(16'h2000, 1'b0, 16'h0000);
		bcu_core_model_inst.boundary();
		req(2'b00);
		bcu_core_model_inst.cycle(16'h2000, 1'b1, 16'h0000);
		bcu_core_model_inst.boundary();
		req(2'b01);
	endtask
	task automatic s_full();
		wr(4'h1, 8'hC0);
		wr(4'h2, 8'h00);
		wr(4'h5, 8'h30);
		wr(4'h8, 8'h55);
		wr(4'h9, 8'hAA);
		bcu_core_model_inst.cycle(16'h3000, 1'b1, 16'h1111);
		bcu_core_model_inst.boundary();
		req(2'b00);
		bcu_core_model_inst.cycle(16'h3000, 1'b1, 16'h55AA);
		bcu_core_model_inst.boundary();
		req(2'b01);
		wr(4'h1, 8'hD0);
		bcu_core_model_inst.tag(16'h3000);
		req(2'b01);
	endtask
	task automatic s_trace();
		wr(4'h1, 8'h00);
		secured <= 1'b1;
		wr(4'h0, 8'h80);
		repeat (2) @(posedge clock);
		#1 chk({15'h0000, trace_mode}, 16'h0000);
		@(posedge clock);
		secured <= 1'b0;
		repeat (2) @(posedge clock);
		#1 chk({15'h0000, trace_mode}, 16'h0001);
		bcu_core_model_inst.cycle(16'h3000, 1'b1, 16'h0000);
		#1 chk({15'h0000, match_a}, 16'h0001);
		@(posedge clock);
		wr(4'h1, 8'h80);
		repeat (2) @(posedge clock);
		#1 chk({15'h0000, trace_mode}, 16'h0000);
	endtask
	// page type compare in trace mode, B and C matches, flash compare in breakpoint mode
	task automatic s_page();
		@(posedge clock);
		wr(4'h1, 8'h00);
		wr(4'h4, 8'h41);
		wr(4'h5, 8'hF0);
		bus_xaddr <= 8'h07;
		bcu_core_model_inst.cycle(16'h3000, 1'b1, 16'h0000);
		#1 chk({15'h0000, match_a}, 16'h0001);
		@(posedge clock);
		bus_xaddr <= 8'h0B;
		bcu_core_model_inst.cycle(16'h3000, 1'b1, 16'h0000);
		#1 chk({15'h0000, match_a}, 16'h0000);
		@(posedge clock);
		wr(4'h1, 8'h08);
		bcu_core_model_inst.cycle(16'h55AA, 1'b0, 16'h0000);
		#1 chk({15'h0000, match_b}, 16'h0001);
		@(posedge clock);
		bcu_core_model_inst.cycle(16'h1234, 1'b0, 16'h0000);
		#1 chk({15'h0000, match_c}, 16'h0001);
		@(posedge clock);
		wr(4'h1, 8'h90);
		exec_flash <= 1'b1;
		exec_xaddr <= 8'h01;
		bcu_core_model_inst.tag(16'hB000);
		req(2'b01);
		exec_flash <= 1'b0;
		bcu_core_model_inst.tag(16'hB000);
		req(2'b00);
	endtask
	// main sequence
	initial begin
		{reg_write, reg_read, reg_addr, reg_wdata} = '0;
		{background_active, single_step_command, external_break, secured} = '0;
		{bus_xaddr, exec_xaddr, bus_flash, exec_flash} = '0;
		bad_count = 0;
		total_checks = 0;
		cycles = 0;
		sys_rst = 1'b1;
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		s_tag_zero();
		s_forced_c();
		s_dual_a();
		s_full();
		s_trace();
		s_page();
		conclude();
	end
endmodule // bcu_breakpoint_comparator_bench
bind bcu_breakpoint_comparator bcu_checker bcu_checker_inst (.clock(clock), .sys_rst(sys_rst),
	.reg_read(reg_read), .reg_rdata(reg_rdata), .bus_valid(bus_valid), .exec_strobe(exec_strobe),
	.instr_boundary(instr_boundary), .background_active(background_active), .secured(secured),
	.external_break(external_break), .background_request(background_request), .match_a(match_a),
	.software_interrupt_request(software_interrupt_request), .match_b(match_b),
	.match_c(match_c), .trace_mode(trace_mode));
`default_nettype wire

// ==== tb/bcu_checker_asserts.sv ====
// port-level assertions for the breakpoint comparator unit
`timescale 1ns/100ps
`default_nettype none
module bcu_checker (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic bus_valid,
	input wire logic instr_boundary,
	input wire logic exec_strobe,
	input wire logic background_active,
	input wire logic external_break,
	input wire logic secured,
	input wire logic background_request,
	input wire logic software_interrupt_request,
	input wire logic match_a,
	input wire logic match_b,
	input wire logic match_c,
	input wire logic trace_mode
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// reset, read data, request, match and trace mode checks
	// ----------------------------------------
	reset_clear_a: assert property (disable iff (1'b0) sys_rst |=> !background_request &&
		!software_interrupt_request && !match_a && !match_b && !match_c && !trace_mode)
		else $error("outputs not cleared by reset");
	rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	pair_excl_a: assert property (!(background_request && software_interrupt_request))
		else $error("both requests at once");
	firmware_block_a: assert property (background_active |=> !background_request &&
		!software_interrupt_request) else $error("request in debug firmware");
	external_prio_a: assert property (external_break |=> !background_request &&
		!software_interrupt_request) else $error("request beside external break");
	secure_trace_a: assert property (secured |=> !trace_mode)
		else $error("trace mode while secured");
	match_cause_a: assert property ((match_a || match_b || match_c) |->
		$past(bus_valid) || $past(exec_strobe)) else $error("match without bus cycle");
	request_cause_a: assert property ((background_request || software_interrupt_request) |->
		$past(instr_boundary) || $past(exec_strobe)) else $error("request off boundary");
endmodule // bcu_checker
`default_nettype wire

// ==== tb/bcu_core_model.sv ====
// behavioural core bus model on the far side of the unit
`timescale 1ns/100ps
`default_nettype none
module bcu_core_model (
	input wire logic clock,
	output logic bus_valid,
	output logic [15:0] bus_addr,
	output logic bus_rw,
	output logic [15:0] bus_data,
	output logic instr_boundary,
	output logic exec_strobe,
	output logic [15:0] exec_addr
);
	// idle bus at time zero
	initial begin
		bus_valid = 1'b0;
		bus_addr = 16'hFFFF;
		bus_rw = 1'b0;
		bus_data = 16'h0000;
		instr_boundary = 1'b0;
		exec_strobe = 1'b0;
		exec_addr = 16'hFFFF;
	end
	// one bus cycle; released lines show the inverse, not the old value
	task automatic cycle(input logic [15:0] a, input logic rw, input logic [15:0] d);
		@(posedge clock);
		bus_valid <= 1'b1;
		bus_addr <= a;
		bus_rw <= rw;
		bus_data <= d;
		@(posedge clock);
		bus_valid <= 1'b0;
		bus_addr <= ~a;
		bus_rw <= ~rw;
		bus_data <= ~d;
	endtask
	// one instruction boundary pulse
	task automatic boundary();
		instr_boundary <= 1'b1;
		@(posedge clock);
		instr_boundary <= 1'b0;
	endtask
	// instruction at address a about to execute
	task automatic tag(input logic [15:0] a);
		exec_strobe <= 1'b1;
		exec_addr <= a;
		@(posedge clock);
		exec_strobe <= 1'b0;
		exec_addr <= ~a;
	endtask
endmodule // bcu_core_model
`default_nettype wire
